// *** synth_ctl.sv ***
// control and status register bank of a two-configuration clock synthesizer
// Summary of operation
// RULE_01: per set, one driver kind bit per pair; 0 pecl style, 1 lvds style
// RULE_02: two full config sets kept; only the selected set drives the synthesizer
// RULE_03: each set holds a 17-bit reference pre-divide
// RULE_04: each set holds a 17-bit lower loop feedback divide
// RULE_05: each set holds 8-bit integer and 18-bit fractional upper loop divide
// RULE_06: each set holds 11-bit output divide and 7-bit op settings
// RULE_07: pll mode 00 low bw, 01 synth, 10 and 11 high bw
// RULE_08: config source bit 0 gives pin control, 1 register control
// RULE_09: config choice bit only acts while config source bit is 1
// RULE_10: output enabled only when register bit and pin both set
// RULE_11: host writes zero into reserved bit positions
// RULE_12: input select mode 00 pin, 01 auto nonrevert, 10 auto revert, 11 reg
// RULE_13: clock choice picks input in reg mode, primary in auto, ignored in pin mode
// RULE_14: adc sample clock is crystal over 16, 8, 4 or 2
// RULE_15: lock window 125 ns, 500 ns, 2 us or 8 us by code
// RULE_16: phase buildout applied on switchover unless its off bit is 1
// RULE_17: doubler bit doubles crystal before the phase detector
// RULE_18: per input fault flag, live, self clearing, mirrored on a pin
// RULE_19: crystal fault flag live, self clearing, mirrored on a pin
// RULE_20: lock flag 1 when locked, 0 when not, mirrored on a pin
// RULE_21: hold flag 1 when detector input bad and oscillator frozen
// RULE_22: active input flag tracks fail-over switching, mirrored on a pin
// RULE_23: serial slave address is 11011 then the two strap bits
// RULE_24: successive data bytes go to ascending registers, msb first
// RULE_25: writes to status positions ignored; reads return live monitor state
`timescale 1ns/1ps
`default_nettype none
`include "synth_ctl_regs.svh"

module synth_ctl
  import synth_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins from the board
  input  wire logic        cfg_sel_pin,
  input  wire logic        out0_enable_pin,
  input  wire logic        out1_enable_pin,
  input  wire logic        clk_sel_pin,
  input  wire logic        addr_strap_low,
  input  wire logic        addr_strap_high,
  // monitors from the analog core
  input  wire status_t     monitor_in,
  // selected configuration and controls to the core
  output cfg_set_t         active_cfg,
  output global_ctrl_t     gctrl,
  output logic             out0_on,
  output logic             out1_on,
  output logic             clk_pick,
  output logic [4:0]       adc_div,
  output logic [11:0]      window_cycles,
  output logic             buildout_on,
  output logic             xtal_x2,
  output logic [6:0]       slave_addr,
  // status pins
  output status_t          status_pins
);

  cfg_set_t     cfg_reg [2];
  global_ctrl_t gctrl_reg;
  status_t      s1_reg, s2_reg, s3_reg, stat_reg;
  logic [4:0]   pin1_reg, pin2_reg, pin3_reg, pin_reg;
  logic         cfg_idx;
  logic         wr_en, rd_en, addr_ok;
  logic [31:0]  rd_next;
  logic [6:0]   slave_addr_next;

  // merge write data under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // pack one set into its three words
  function automatic logic [95:0] pack_cfg(input cfg_set_t c);
    logic [31:0] a, b, w;
    a = 32'h0000_0000;
    b = 32'h0000_0000;
    w = 32'h0000_0000;
    a[`F_PREDIV_LSB +: 17] = c.ref_prediv;
    a[`F_FBINT_LSB +: 8]   = c.upper_loop_fb_int;
    b[`F_LOWFB_LSB +: 17]  = c.lower_loop_fb_int;
    b[`F_OUTDIV_LSB +: 11] = c.out_divide;
    w[`F_FRAC_LSB +: 18]   = c.upper_loop_fb_frac;
    w[`F_OPSET_LSB +: 7]   = c.internal_op_settings;
    w[`F_KIND0_BIT]        = c.pair0_driver_kind;
    w[`F_KIND1_BIT]        = c.pair1_driver_kind;
    return {a, b, w};
  endfunction

  function automatic logic [31:0] pack_gctrl(input global_ctrl_t g);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[`F_LCKWIN_LSB +: 2]  = g.edge_window_width;
    r[`F_ADC_LSB +: 2]     = g.adc_rate;
    r[`F_CLKSEL_BIT]       = g.clk_choice;
    r[`F_INMODE_LSB +: 2]  = g.input_sel_mode;
    r[`F_OE0_BIT]          = g.out0_enable;
    r[`F_OE1_BIT]          = g.out1_enable;
    r[`F_CFGSRC_BIT]       = g.cfg_src_reg;
    r[`F_CFGREG_BIT]       = g.cfg_choice;
    r[`F_PLLMODE_LSB +: 2] = g.pll_mode;
    r[`F_PBO_OFF_BIT]      = g.phase_buildout_off;
    r[`F_DOUBLER_BIT]      = g.crystal_doubler;
    return r;
  endfunction

  function automatic global_ctrl_t unpack_gctrl(input logic [31:0] r);
    global_ctrl_t g;
    g.edge_window_width  = r[`F_LCKWIN_LSB +: 2];
    g.adc_rate           = r[`F_ADC_LSB +: 2];
    g.clk_choice         = r[`F_CLKSEL_BIT];
    g.input_sel_mode     = input_sel_mode_t'(r[`F_INMODE_LSB +: 2]);
    g.out0_enable        = r[`F_OE0_BIT];
    g.out1_enable        = r[`F_OE1_BIT];
    g.cfg_src_reg        = r[`F_CFGSRC_BIT];
    g.cfg_choice         = r[`F_CFGREG_BIT];
    g.pll_mode           = pll_mode_t'(r[`F_PLLMODE_LSB +: 2]);
    g.phase_buildout_off = r[`F_PBO_OFF_BIT];
    g.crystal_doubler    = r[`F_DOUBLER_BIT];
    return g;
  endfunction

  // apb decode: zero wait states
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  always_comb begin
    case (paddr)
      `OFS_CFG0_A, `OFS_CFG0_B, `OFS_CFG0_C,
      `OFS_CFG1_A, `OFS_CFG1_B, `OFS_CFG1_C,
      `OFS_GCTRL, `OFS_GSTAT, `OFS_ACTIVE_CFG: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  // pin inputs pass three flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin1_reg <= 5'h00;
      pin2_reg <= 5'h00;
      pin3_reg <= 5'h00;
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
    end else begin
      pin1_reg <= {addr_strap_high, addr_strap_low, clk_sel_pin, out1_enable_pin,
                   out0_enable_pin};
      pin2_reg <= pin1_reg;
      pin3_reg <= pin2_reg;
      s1_reg   <= monitor_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
    end
  end

  // config select pin has its own three-flop chain
  logic cs1_reg, cs2_reg, cs3_reg, cs_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs1_reg <= 1'b0;
      cs2_reg <= 1'b0;
      cs3_reg <= 1'b0;
      cs_reg  <= 1'b0;
    end else begin
      cs1_reg <= cfg_sel_pin;
      cs2_reg <= cs1_reg;
      cs3_reg <= cs2_reg;
      if (cs2_reg == cs3_reg) begin
        cs_reg <= cs3_reg;
      end
    end
  end

  // accept a pin change once stages two and three agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_reg  <= 5'h03;
      stat_reg <= '0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (pin2_reg[i] == pin3_reg[i]) begin
          pin_reg[i] <= pin3_reg[i];
        end
      end
      for (int i = 0; i < 6; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          stat_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // RULE_02 RULE_03 RULE_04: two config set writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg[0] <= '0;
      cfg_reg[1] <= '0;
    end else if (wr_en) begin
      for (int s = 0; s < 2; s++) begin
        logic [95:0] w;
        logic [31:0] a, b, c;
        w = pack_cfg(cfg_reg[s]);
        a = w[95:64];
        b = w[63:32];
        c = w[31:0];
        // RULE_05 RULE_06 RULE_01: word fields per set
        if (paddr == (s == 0 ? `OFS_CFG0_A : `OFS_CFG1_A)) begin
          a = merge(a, pwdata, pstrb);
        end
        if (paddr == (s == 0 ? `OFS_CFG0_B : `OFS_CFG1_B)) begin
          b = merge(b, pwdata, pstrb);
        end
        if (paddr == (s == 0 ? `OFS_CFG0_C : `OFS_CFG1_C)) begin
          c = merge(c, pwdata, pstrb);
        end
        cfg_reg[s].ref_prediv           <= a[`F_PREDIV_LSB +: 17];
        cfg_reg[s].upper_loop_fb_int    <= a[`F_FBINT_LSB +: 8];
        cfg_reg[s].lower_loop_fb_int    <= b[`F_LOWFB_LSB +: 17];
        cfg_reg[s].out_divide           <= b[`F_OUTDIV_LSB +: 11];
        cfg_reg[s].upper_loop_fb_frac   <= c[`F_FRAC_LSB +: 18];
        cfg_reg[s].internal_op_settings <= c[`F_OPSET_LSB +: 7];
        cfg_reg[s].pair0_driver_kind    <= c[`F_KIND0_BIT];
        cfg_reg[s].pair1_driver_kind    <= c[`F_KIND1_BIT];
      end
    end
  end

  // global control write; unused bits read back zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gctrl_reg <= unpack_gctrl(`RST_GCTRL);
    end else if (wr_en && paddr == `OFS_GCTRL) begin
      gctrl_reg <= unpack_gctrl(merge(pack_gctrl(gctrl_reg), pwdata, pstrb));
    end
  end

  // RULE_08 RULE_09: pick the governing set
  assign cfg_idx = gctrl_reg.cfg_src_reg ? gctrl_reg.cfg_choice : cs_reg;

  // RULE_02: selected set drives the core
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_cfg <= '0;
    end else begin
      active_cfg <= cfg_reg[cfg_idx];
    end
  end

  // control outputs to the core
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gctrl         <= unpack_gctrl(`RST_GCTRL);
      out0_on       <= 1'b0;
      out1_on       <= 1'b0;
      clk_pick      <= 1'b0;
      adc_div       <= 5'h04;
      window_cycles <= 12'(`NS_TO_CYC(`WIN_CODE0_NS));
      buildout_on   <= 1'b1;
      xtal_x2       <= 1'b0;
    end else begin
      gctrl   <= gctrl_reg;
      // RULE_07: both high bandwidth codes reach the core as one
      if (gctrl_reg.pll_mode == MODE_HIGH_B2) begin
        gctrl.pll_mode <= MODE_HIGH_BW;
      end
      // RULE_10: register bit and pin both
      out0_on <= gctrl_reg.out0_enable && pin_reg[0];
      out1_on <= gctrl_reg.out1_enable && pin_reg[1];
      // RULE_12 RULE_13: input choice per mode
      case (gctrl_reg.input_sel_mode)
        INSEL_PIN: clk_pick <= pin_reg[2];
        INSEL_REG: clk_pick <= gctrl_reg.clk_choice;
        default:   clk_pick <= gctrl_reg.clk_choice; // primary input
      endcase
      // RULE_14: adc divide ratio
      case (gctrl_reg.adc_rate)
        2'b00:   adc_div <= 5'h10;
        2'b01:   adc_div <= 5'h08;
        2'b10:   adc_div <= 5'h04;
        default: adc_div <= 5'h02;
      endcase
      // RULE_15: lock window in cycles
      case (gctrl_reg.edge_window_width)
        2'b00:   window_cycles <= 12'(`NS_TO_CYC(`WIN_CODE0_NS));
        2'b01:   window_cycles <= 12'(`NS_TO_CYC(`WIN_CODE1_NS));
        2'b10:   window_cycles <= 12'(`NS_TO_CYC(`WIN_CODE2_NS));
        default: window_cycles <= 12'(`NS_TO_CYC(`WIN_CODE3_NS));
      endcase
      // RULE_16: buildout unless switched off
      buildout_on <= !gctrl_reg.phase_buildout_off;
      // RULE_17: crystal doubler
      xtal_x2     <= gctrl_reg.crystal_doubler;
    end
  end

  // RULE_23: slave address from the synchronised straps, reloaded every cycle after reset release
  assign slave_addr_next = {`SLAVE_ADDR_HI, pin_reg[4], pin_reg[3]};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slave_addr <= 7'h00;
    end else begin
      slave_addr <= slave_addr_next;
    end
  end

  // RULE_18 RULE_19 RULE_20 RULE_21 RULE_22: live flags mirrored on pins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_pins <= '0;
    end else begin
      status_pins <= stat_reg;
    end
  end

  // RULE_24: registers at ascending word offsets, msb at bit 31
  // read mux; RULE_25: status word is live and not writable
  always_comb begin
    logic [95:0] w0, w1;
    w0 = pack_cfg(cfg_reg[0]);
    w1 = pack_cfg(cfg_reg[1]);
    rd_next = 32'h0000_0000;
    case (paddr)
      `OFS_CFG0_A: rd_next = w0[95:64];
      `OFS_CFG0_B: rd_next = w0[63:32];
      `OFS_CFG0_C: rd_next = w0[31:0];
      `OFS_CFG1_A: rd_next = w1[95:64];
      `OFS_CFG1_B: rd_next = w1[63:32];
      `OFS_CFG1_C: rd_next = w1[31:0];
      `OFS_GCTRL:  rd_next = pack_gctrl(gctrl_reg);
      `OFS_GSTAT: begin
        rd_next[`F_LOCK_BIT]  = stat_reg.pll_locked_flag;
        rd_next[`F_XTAL_BIT]  = stat_reg.crystal_fault;
        rd_next[`F_IN0_BIT]   = stat_reg.input0_fault;
        rd_next[`F_IN1_BIT]   = stat_reg.input1_fault;
        rd_next[`F_HOLD_BIT]  = stat_reg.freeze_hold_flag;
        rd_next[`F_ACTIN_BIT] = stat_reg.active_input;
      end
      `OFS_ACTIVE_CFG: rd_next = {31'h0000_0000, cfg_idx};
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // read data captured in setup, stable through the access cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_next;
    end
  end

endmodule
`default_nettype wire

// *** synth_ctl_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef SYNTH_CTL_REGS_SVH
`define SYNTH_CTL_REGS_SVH

// byte offsets of the 32-bit register words
`define OFS_CFG0_A      12'h000
`define OFS_CFG0_B      12'h004
`define OFS_CFG0_C      12'h008
`define OFS_CFG1_A      12'h010
`define OFS_CFG1_B      12'h014
`define OFS_CFG1_C      12'h018
`define OFS_GCTRL       12'h020
`define OFS_GSTAT       12'h024
`define OFS_ACTIVE_CFG  12'h028

// cfg word a: ref_prediv[16:0], upper_loop_fb_int[24:17]
`define F_PREDIV_LSB    0
`define F_FBINT_LSB     17
// cfg word b: lower_loop_fb_int[16:0], out_divide[27:17]
`define F_LOWFB_LSB     0
`define F_OUTDIV_LSB    17
// cfg word c: upper_loop_fb_frac[17:0], op settings[24:18], kinds[26:25]
`define F_FRAC_LSB      0
`define F_OPSET_LSB     18
`define F_KIND0_BIT     25
`define F_KIND1_BIT     26

// global control word
`define F_LCKWIN_LSB    0
`define F_ADC_LSB       2
`define F_CLKSEL_BIT    4
`define F_INMODE_LSB    5
`define F_OE0_BIT       7
`define F_OE1_BIT       8
`define F_CFGSRC_BIT    9
`define F_CFGREG_BIT    10
`define F_PLLMODE_LSB   11
`define F_PBO_OFF_BIT   13
`define F_DOUBLER_BIT   14

// global status word
`define F_LOCK_BIT      0
`define F_XTAL_BIT      1
`define F_IN0_BIT       2
`define F_IN1_BIT       3
`define F_HOLD_BIT      4
`define F_ACTIN_BIT     5

// reset values: outputs enabled, adc /4, window 125 ns
`define RST_GCTRL       32'h0000_0188

// lock windows in ns and their cycle counts at the 4 ns clock
`define CLK_PERIOD_NS   4
`define WIN_CODE0_NS    125
`define WIN_CODE1_NS    500
`define WIN_CODE2_NS    2000
`define WIN_CODE3_NS    8000
`define NS_TO_CYC(ns)   ((ns) / `CLK_PERIOD_NS)

// serial slave address upper five bits
`define SLAVE_ADDR_HI   5'h1b

`endif

// *** synth_ctl_pkg.sv ***
// types shared by the clock synthesizer control block
package synth_ctl_pkg;

  typedef enum logic [1:0] {
    MODE_LOW_BW  = 2'b00,
    MODE_SYNTH   = 2'b01,
    MODE_HIGH_BW = 2'b10,
    MODE_HIGH_B2 = 2'b11
  } pll_mode_t;

  typedef enum logic [1:0] {
    INSEL_PIN     = 2'b00,
    INSEL_AUTO_NR = 2'b01,
    INSEL_AUTO_RV = 2'b10,
    INSEL_REG     = 2'b11
  } input_sel_mode_t;

  typedef struct packed {
    logic [16:0] ref_prediv;
    logic [16:0] lower_loop_fb_int;
    logic [7:0]  upper_loop_fb_int;
    logic [17:0] upper_loop_fb_frac;
    logic [10:0] out_divide;
    logic [6:0]  internal_op_settings;
    logic        pair0_driver_kind;
    logic        pair1_driver_kind;
  } cfg_set_t;

  typedef struct packed {
    pll_mode_t       pll_mode;
    logic            cfg_src_reg;
    logic            cfg_choice;
    logic            out1_enable;
    logic            out0_enable;
    input_sel_mode_t input_sel_mode;
    logic            clk_choice;
    logic [1:0]      adc_rate;
    logic [1:0]      edge_window_width;
    logic            phase_buildout_off;
    logic            crystal_doubler;
  } global_ctrl_t;

  typedef struct packed {
    logic input0_fault;
    logic input1_fault;
    logic crystal_fault;
    logic pll_locked_flag;
    logic freeze_hold_flag;
    logic active_input;
  } status_t;

endpackage

// *** clock_synth_assertions.sv ***
// assertion checker for the synthesizer control register bank
`timescale 1ns/1ps
`default_nettype none
module synth_ctl_checker
  import synth_ctl_pkg::*;
(
  // clock and reset
  input wire logic         mclk,
  input wire logic         rst_n,
  // board pins and monitors
  input wire logic         out1_enable_pin,
  input wire logic         addr_strap_low,
  input wire logic         addr_strap_high,
  input wire status_t      monitor_in,
  // outputs toward the core
  input wire global_ctrl_t gctrl,
  input wire logic         out0_on,
  input wire logic         out1_on,
  input wire logic         clk_pick,
  input wire logic [4:0]   adc_div,
  input wire logic [11:0]  window_cycles,
  input wire logic         buildout_on,
  input wire logic         xtal_x2,
  input wire logic [6:0]   slave_addr,
  input wire status_t      status_pins
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // inputs held long enough to cross the synchronisers
  sequence mon_settled;
    $stable(monitor_in) [*7];
  endsequence
  sequence straps_settled;
    $stable({addr_strap_high, addr_strap_low}) [*7];
  endsequence

  a_mode_folded: assert property (gctrl.pll_mode != MODE_HIGH_B2)
    else $error("second high bandwidth code reached the core unfolded");
  a_out_forced_off: assert property (!gctrl.out0_enable [*3] |-> !out0_on)
    else $error("output 0 on while its register enable is low");
  a_out_both_on: assert property ((gctrl.out1_enable && out1_enable_pin) [*7] |-> out1_on)
    else $error("output 1 off while register bit and pin are high");
  a_adc_rate_map: assert property ($stable(gctrl.adc_rate) |-> adc_div == (5'h10 >> gctrl.adc_rate))
    else $error("sample divider does not follow rate code");
  a_lock_window_map: assert property ($stable(gctrl.edge_window_width) |->
      window_cycles == (gctrl.edge_window_width == 2'd0 ? 12'd31 :
                        12'd125 << {gctrl.edge_window_width - 2'd1, 1'b0}))
    else $error("lock window count does not follow code");
  a_buildout_map: assert property ($stable(gctrl.phase_buildout_off) |-> buildout_on == !gctrl.phase_buildout_off)
    else $error("build-out enable not inverse of its off bit");
  a_doubler_map: assert property ($stable(gctrl.crystal_doubler) |-> xtal_x2 == gctrl.crystal_doubler)
    else $error("doubler output does not follow its bit");
  a_status_mirror: assert property (mon_settled |-> status_pins == monitor_in)
    else $error("status pins do not mirror settled monitors");
  a_slave_addr_form: assert property (straps_settled |-> slave_addr == {5'h1b, addr_strap_high, addr_strap_low})
    else $error("slave address not formed from straps");
  a_clk_pick_reg: assert property (($stable(gctrl) && gctrl.input_sel_mode != INSEL_PIN) [*2] |-> clk_pick == gctrl.clk_choice)
    else $error("picked input differs from register choice");
endmodule

bind synth_ctl synth_ctl_checker synth_ctl_checker_inst (
  .mclk, .rst_n, .out1_enable_pin, .addr_strap_low, .addr_strap_high, .monitor_in, .gctrl,
  .out0_on, .out1_on, .clk_pick, .adc_div, .window_cycles, .buildout_on, .xtal_x2,
  .slave_addr, .status_pins
);
`default_nettype wire

// *** apb_host.sv ***
// apb host model driving the register bus of the synthesizer block
`timescale 1ns/1ps
`default_nettype none
module apb_host (
  // clock
  input  wire logic        mclk,
  // request
  output var logic         psel,
  output var logic         penable,
  output var logic         pwrite,
  output var logic  [11:0] paddr,
  output var logic  [31:0] pwdata,
  output var logic  [3:0]  pstrb,
  // answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
  end

  function automatic logic [31:0] wmask(input logic [11:0] a);
    case (a)
      12'h000, 12'h010: return 32'h01ff_ffff;
      12'h004, 12'h014: return 32'h0fff_ffff;
      12'h008, 12'h018: return 32'h07ff_ffff;
      12'h020: return 32'h0000_7fff;
      default: return 32'hffff_ffff;
    endcase
  endfunction

  // setup, then access held until pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d & wmask(a);
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // released lines stop showing the last value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~pwdata;
  endtask
endmodule
`default_nettype wire

// *** test_clock_synth_control_status_regs.sv ***
// self-checking bench for the synthesizer control register bank
`timescale 1ns/1ps
`default_nettype none
`include "synth_ctl_regs.svh"
module test_clock_synth_control_status_regs;
  import synth_ctl_pkg::*;
  logic         mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]  paddr, window_cycles;
  logic [31:0]  pwdata, prdata, rd, v, seed;
  logic [3:0]   pstrb;
  logic         cfg_sel_pin, out0_enable_pin, out1_enable_pin, clk_sel_pin;
  logic         addr_strap_low, addr_strap_high, out0_on, out1_on, clk_pick;
  logic         buildout_on, xtal_x2;
  logic [4:0]   adc_div;
  logic [6:0]   slave_addr;
  status_t      monitor_in, status_pins;
  cfg_set_t     active_cfg;
  global_ctrl_t gctrl;
  int           fails, compares, s;
  int unsigned  mdl [12];

  synth_ctl synth_ctl_inst (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .cfg_sel_pin, .out0_enable_pin, .out1_enable_pin, .clk_sel_pin,
    .addr_strap_low, .addr_strap_high, .monitor_in, .active_cfg, .gctrl, .out0_on, .out1_on,
    .clk_pick, .adc_div, .window_cycles, .buildout_on, .xtal_x2, .slave_addr, .status_pins);
  apb_host apb_host_inst (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr);

  // clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] next_rand();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb_host_inst.xfer(1'b1, a, d, rd, err);
    if (a < 12'h024) mdl[a[5:2]] = d & apb_host_inst.wmask(a);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb_host_inst.xfer(1'b0, a, 32'h0000_0000, rd, err);
    check(rd, exp);
  endtask

  // expected set and control copy from the model words
  function automatic cfg_set_t exp_set(input int k);
    logic [31:0] a, b, c;
    a = mdl[4 * k];
    b = mdl[4 * k + 1];
    c = mdl[4 * k + 2];
    return {a[16:0], b[16:0], a[24:17], c[17:0], b[27:17], c[24:18], c[25], c[26]};
  endfunction
  function automatic global_ctrl_t exp_g();
    logic [31:0] g;
    g = mdl[8];
    return global_ctrl_t'({g[12], g[11] & !g[12], g[9], g[10], g[8], g[7], g[6:5], g[4],
                           g[3:2], g[1:0],
                           g[13], g[14]});
  endfunction

  task automatic readback();
    for (int i = 0; i < 9; i++) begin
      if (i % 4 != 3) begin
        rd_chk(12'(4 * i), mdl[i]);
      end
    end
  endtask

  task automatic wrap_up();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    seed = 32'h0001_2875;
    {cfg_sel_pin, clk_sel_pin, addr_strap_low, addr_strap_high} = 4'h0;
    {out0_enable_pin, out1_enable_pin} = 2'b11;
    monitor_in = '0;
    fails = 0;
    compares = 0;
    foreach (mdl[i]) mdl[i] = 0;
    mdl[8] = `RST_GCTRL;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values, then random set contents
    readback();
    for (int i = 0; i < 7; i++) begin
      if (i % 4 != 3) wr(12'(4 * i), next_rand());
    end
    readback();
    // every source and choice against the select pin
    for (int i = 0; i < 8; i++) begin
      cfg_sel_pin <= i[0];
      wr(12'h020, (mdl[8] & ~32'h0000_0600) | {21'h0, i[2:1], 9'h0});
      repeat (6) @(posedge mclk);
      s = i[1] ? i[2] : i[0];
      check(active_cfg, exp_set(s));
      rd_chk(12'h028, 32'(s));
    end
    // every mode, rate and window code with random pins
    for (int i = 0; i < 8; i++) begin
      v = next_rand();
      v[12:11] = i[1:0];
      v[3:2] = i[1:0];
      v[6:5] = i[2:1];
      v[1:0] = i[2:1];
      {out1_enable_pin, out0_enable_pin, clk_sel_pin} <= v[31:29];
      wr(12'h020, v);
      repeat (6) @(posedge mclk);
      check(gctrl, exp_g());
      check({out1_on, out0_on}, {mdl[8][8] & v[31], mdl[8][7] & v[30]});
      check(clk_pick, mdl[8][6:5] == 2'b00 ? v[29] : mdl[8][4]);
      check(adc_div, 5'h10 >> mdl[8][3:2]);
      check(window_cycles, (`WIN_CODE0_NS << (2 * mdl[8][1:0])) / `CLK_PERIOD_NS);
      check({buildout_on, xtal_x2}, {!mdl[8][13], mdl[8][14]});
      rd_chk(12'h020, mdl[8]);
    end
    // live flags, host writes to them ignored
    for (int i = 0; i < 6; i++) begin
      v = next_rand();
      monitor_in <= v[5:0];
      {addr_strap_high, addr_strap_low} <= v[7:6];
      wr(12'h024, 32'h0000_003f);
      repeat (6) @(posedge mclk);
      check(status_pins, v[5:0]);
      check(slave_addr, {5'h1b, v[7:6]});
      rd_chk(12'h024, {26'h0, v[0], v[1], v[4], v[5], v[3], v[2]});
    end
    // unmapped word answers with an error and zero data
    apb_host_inst.xfer(1'b0, 12'h00c, 32'h0000_0000, rd, err);
    check({err, rd}, {1'b1, 32'h0000_0000});
    wrap_up();
  end
endmodule
`default_nettype wire
